/* File: hw/dmr_mode_regs.v */
// Summary of operation
// - mode pointer reset or set by command; mode one access moves it to two
// - with bit 7 set, start bit into full fifo negates request-to-send
// - output register bit 0 asserts request-to-send, clearing it negates
// - auto negation keeps bit 0; request-to-send returns when fifo frees
// - bit 6 picks receiver-ready or fifo-full as receiver interrupt source
// - chosen receiver status drives output bit four when so configured
// - character error mode shows errors of the fifo top character only
// - block error mode ORs errors of all top characters since reset-error
// - with or forced parity adds a parity bit and checks it on receive
// - parity field 11 selects multidrop mode instead of parity
// - parity type picks odd/even or forced level; ignored with no parity
// - in multidrop the parity type sets address/data bit polarity
// - two-bit field gives data bits per character, excluding framing bits
// - aux control bit 7 selects rate generator set one or two
// - status and mask share one layout; set mask bit enables source
// - interrupt select 0 is receiver-ready, 1 is fifo-full
// - error mode 0 is character mode, 1 is block mode
// - parity field 00 with, 01 forced, 10 none, 11 multidrop
// - parity type 0 even, 1 odd
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dmr_regs.vh"

module dmr_mode_regs #(
	parameter ADDR_W = 8,
	parameter NIN = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire rx_start_valid,
	input wire fifo_full,
	input wire receiver_ready,
	input wire rx_top_load,
	input wire top_framing_error,
	input wire top_parity_error,
	input wire top_break,
	input wire transmitter_ready_a,
	input wire transmitter_ready_b,
	input wire rx_int_b,
	input wire break_change_a,
	input wire break_change_b,
	input wire counter_ready,
	input wire [NIN-1:0] in_pins,
	output reg chan_a_request_to_send_n,
	output reg output_bit_four,
	output reg intr_request,
	output reg parity_enable,
	output reg parity_forced,
	output reg parity_odd,
	output reg multidrop,
	output reg addr_data_polarity,
	output reg [1:0] char_bits,
	output reg baud_set_two,
	output reg [15:0] counter_preset,
	output reg [7:0] chan_a_mode_two_out
);
	reg [7:0] channel_a_mode_one;
	reg [7:0] channel_a_mode_two;
	reg [7:0] aux_control;
	reg [7:0] interrupt_mask;
	reg [7:0] counter_preset_high;
	reg [7:0] counter_preset_low;
	reg [7:0] output_port_register;
	reg [7:0] output_port_config;
	reg mode_ptr;
	reg rts_auto_hold;
	reg [2:0] block_err;
	reg [NIN-1:0] delta;
	reg aw_held;
	reg w_held;
	reg [ADDR_W-1:0] aw_addr;
	reg [7:0] w_byte;
	reg w_lane0;
	wire [NIN-1:0] in_level;
	wire [NIN-1:0] in_change;
	wire wr_go;
	wire rd_go;
	wire err_clr;
	reg [2:0] err_view;
	reg rx_sel;
	reg [7:0] interrupt_status;
	reg [7:0] input_change_status;

	// true when an address names a mapped register
	function mapped;
		input [ADDR_W-1:0] a;
		begin
			if (a == `DMR_OFS_MODE) mapped = 1'b1;
			else if (a == `DMR_OFS_AUX) mapped = 1'b1;
			else if (a == `DMR_OFS_IPCHG) mapped = 1'b1;
			else if (a == `DMR_OFS_ISTAT) mapped = 1'b1;
			else if (a == `DMR_OFS_IMASK) mapped = 1'b1;
			else if (a == `DMR_OFS_CPHI) mapped = 1'b1;
			else if (a == `DMR_OFS_CPLO) mapped = 1'b1;
			else if (a == `DMR_OFS_OPR) mapped = 1'b1;
			else if (a == `DMR_OFS_CMD) mapped = 1'b1;
			else if (a == `DMR_OFS_CSTAT) mapped = 1'b1;
			else if (a == `DMR_OFS_OPCFG) mapped = 1'b1;
			else mapped = 1'b0;
		end
	endfunction

	dmr_input_sync #(
		.W(NIN)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pins(in_pins),
		.level(in_level),
		.change(in_change)
	);

	// address and data are taken independently, in either order
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && !s_axi_rvalid;
	// reset-error command strobe
	assign err_clr = wr_go && w_lane0 && aw_addr == `DMR_OFS_CMD && w_byte[`DMR_CMD_RST_ERR];

	// derived status, combinational
	always @* begin
		rx_sel = channel_a_mode_one[`DMR_M1_RXINT_SEL] ? fifo_full : receiver_ready;
		if (channel_a_mode_one[`DMR_M1_ERR_MODE])
			err_view = block_err;
		else
			err_view = {top_break, top_framing_error, top_parity_error};
		input_change_status = {delta, in_level};
		interrupt_status = 8'h00;
		interrupt_status[`DMR_IS_IN_CHANGE] = |(delta & aux_control[`DMR_AUX_CHG_HI:`DMR_AUX_CHG_LO]);
		interrupt_status[`DMR_IS_BRK_B] = break_change_b;
		interrupt_status[`DMR_IS_RX_B] = rx_int_b;
		interrupt_status[`DMR_IS_TXRDY_B] = transmitter_ready_b;
		interrupt_status[`DMR_IS_CTR] = counter_ready;
		interrupt_status[`DMR_IS_BRK_A] = break_change_a;
		interrupt_status[`DMR_IS_RX_A] = rx_sel;
		interrupt_status[`DMR_IS_TXRDY_A] = transmitter_ready_a;
	end

	// write channel capture
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= {ADDR_W{1'b0}};
			w_byte <= `DMR_RST_BYTE;
			w_lane0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DMR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr) ? `DMR_RESP_OKAY : `DMR_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register file writes and mode pointer
	always @(posedge aclk) begin
		if (!aresetn) begin
			channel_a_mode_one <= `DMR_RST_BYTE;
			channel_a_mode_two <= `DMR_RST_BYTE;
			aux_control <= `DMR_RST_BYTE;
			interrupt_mask <= `DMR_RST_BYTE;
			counter_preset_high <= `DMR_RST_BYTE;
			counter_preset_low <= `DMR_RST_BYTE;
			output_port_register <= `DMR_RST_OPR;
			output_port_config <= `DMR_RST_BYTE;
			mode_ptr <= 1'b0;
		end else begin
			if (wr_go && w_lane0) begin
				if (aw_addr == `DMR_OFS_MODE) begin
					if (mode_ptr)
						channel_a_mode_two <= w_byte;
					else
						channel_a_mode_one <= w_byte;
				end else if (aw_addr == `DMR_OFS_AUX) begin
					aux_control <= w_byte;
				end else if (aw_addr == `DMR_OFS_IMASK) begin
					interrupt_mask <= w_byte;
				end else if (aw_addr == `DMR_OFS_CPHI) begin
					counter_preset_high <= w_byte;
				end else if (aw_addr == `DMR_OFS_CPLO) begin
					counter_preset_low <= w_byte;
				end else if (aw_addr == `DMR_OFS_OPR) begin
					output_port_register <= w_byte;
				end else if (aw_addr == `DMR_OFS_OPCFG) begin
					output_port_config <= w_byte;
				end
			end
			// any mode one access moves pointer to two
			if ((wr_go && aw_addr == `DMR_OFS_MODE && !mode_ptr) ||
				(rd_go && s_axi_araddr == `DMR_OFS_MODE && !mode_ptr))
				mode_ptr <= 1'b1;
			// set-pointer command wins over an access
			if (wr_go && w_lane0 && aw_addr == `DMR_OFS_CMD && w_byte[`DMR_CMD_SET_PTR])
				mode_ptr <= 1'b0;
		end
	end

	// flow control hold and error accumulation
	always @(posedge aclk) begin
		if (!aresetn) begin
			rts_auto_hold <= 1'b0;
			block_err <= 3'h0;
		end else begin
			// release once a fifo slot frees, register bit kept
			if (!fifo_full)
				rts_auto_hold <= 1'b0;
			// start bit into a full fifo
			if (channel_a_mode_one[`DMR_M1_RTS_CTL] && rx_start_valid && fifo_full)
				rts_auto_hold <= 1'b1;
			// clear by reset-error; a new top character still wins
			if (err_clr)
				block_err <= 3'h0;
			// old flags still go on a clear; only the new character's flags survive
			if (rx_top_load)
				block_err <= (err_clr ? 3'h0 : block_err) |
					{top_break, top_framing_error, top_parity_error};
		end
	end

	// change flags: read clears, a change in the same cycle survives
	always @(posedge aclk) begin
		if (!aresetn) begin
			delta <= {NIN{1'b0}};
		end else begin
			if (rd_go && s_axi_araddr == `DMR_OFS_IPCHG)
				delta <= in_change;
			else
				delta <= delta | in_change;
		end
	end

	// read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `DMR_RESP_OKAY;
		end else begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? `DMR_RESP_OKAY : `DMR_RESP_SLVERR;
				s_axi_rdata <= 32'h00000000;
				if (s_axi_araddr == `DMR_OFS_MODE)
					s_axi_rdata[7:0] <= mode_ptr ? channel_a_mode_two : channel_a_mode_one;
				else if (s_axi_araddr == `DMR_OFS_AUX)
					s_axi_rdata[7:0] <= aux_control;
				else if (s_axi_araddr == `DMR_OFS_IPCHG)
					s_axi_rdata[7:0] <= input_change_status;
				else if (s_axi_araddr == `DMR_OFS_ISTAT)
					s_axi_rdata[7:0] <= interrupt_status;
				else if (s_axi_araddr == `DMR_OFS_IMASK)
					s_axi_rdata[7:0] <= interrupt_mask;
				else if (s_axi_araddr == `DMR_OFS_CPHI)
					s_axi_rdata[7:0] <= counter_preset_high;
				else if (s_axi_araddr == `DMR_OFS_CPLO)
					s_axi_rdata[7:0] <= counter_preset_low;
				else if (s_axi_araddr == `DMR_OFS_OPR)
					s_axi_rdata[7:0] <= output_port_register;
				else if (s_axi_araddr == `DMR_OFS_CSTAT) begin
					s_axi_rdata[`DMR_CS_BREAK] <= err_view[2];
					s_axi_rdata[`DMR_CS_FRAME] <= err_view[1];
					s_axi_rdata[`DMR_CS_PARITY] <= err_view[0];
					s_axi_rdata[`DMR_CS_RTS_HOLD] <= rts_auto_hold;
					s_axi_rdata[`DMR_CS_PTR] <= mode_ptr;
					s_axi_rdata[`DMR_CS_FIFO_FULL] <= fifo_full;
					s_axi_rdata[`DMR_CS_RECEIVER_READY] <= receiver_ready;
				end else if (s_axi_araddr == `DMR_OFS_OPCFG)
					s_axi_rdata[7:0] <= output_port_config;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// registered pin and configuration outputs; request-to-send and bit four pins idle high after reset, interrupt request low
	always @(posedge aclk) begin
		if (!aresetn) begin
			chan_a_request_to_send_n <= 1'b1;
			output_bit_four <= 1'b1;
			intr_request <= 1'b0;
			parity_enable <= 1'b0;
			parity_forced <= 1'b0;
			parity_odd <= 1'b0;
			multidrop <= 1'b0;
			addr_data_polarity <= 1'b0;
			char_bits <= 2'h0;
			baud_set_two <= 1'b0;
			counter_preset <= 16'h0000;
			chan_a_mode_two_out <= `DMR_RST_BYTE;
		end else begin
			// pin is inverse of register bit
			// auto hold negates without touching the bit
			chan_a_request_to_send_n <= !(output_port_register[`DMR_OP_RTS] && !rts_auto_hold);
			// receiver status on bit four when configured
			output_bit_four <= output_port_config[`DMR_OP_FOUR] ? !rx_sel :
				!output_port_register[`DMR_OP_FOUR];
			// any enabled status raises the request
			intr_request <= |(interrupt_status & interrupt_mask);
			// with or forced adds and checks parity
			parity_enable <= (channel_a_mode_one[`DMR_M1_PAR_HI:`DMR_M1_PAR_LO] == `DMR_PAR_WITH) ||
				(channel_a_mode_one[`DMR_M1_PAR_HI:`DMR_M1_PAR_LO] == `DMR_PAR_FORCE);
			parity_forced <= channel_a_mode_one[`DMR_M1_PAR_HI:`DMR_M1_PAR_LO] == `DMR_PAR_FORCE;
			// type 1 odd or forced high
			parity_odd <= channel_a_mode_one[`DMR_M1_PAR_TYPE] &&
				((channel_a_mode_one[`DMR_M1_PAR_HI:`DMR_M1_PAR_LO] == `DMR_PAR_WITH) ||
				(channel_a_mode_one[`DMR_M1_PAR_HI:`DMR_M1_PAR_LO] == `DMR_PAR_FORCE));
			multidrop <= channel_a_mode_one[`DMR_M1_PAR_HI:`DMR_M1_PAR_LO] == `DMR_PAR_MDROP;
			addr_data_polarity <= channel_a_mode_one[`DMR_M1_PAR_TYPE] &&
				(channel_a_mode_one[`DMR_M1_PAR_HI:`DMR_M1_PAR_LO] == `DMR_PAR_MDROP);
			char_bits <= channel_a_mode_one[`DMR_M1_BITS_HI:`DMR_M1_BITS_LO];
			baud_set_two <= aux_control[`DMR_AUX_BAUD_SET];
			counter_preset <= {counter_preset_high, counter_preset_low};
			chan_a_mode_two_out <= channel_a_mode_two;
		end
	end
endmodule

`default_nettype wire

/* File: pkg/dmr_regs.vh */
`ifndef DMR_REGS_VH
`define DMR_REGS_VH

// register byte offsets
`define DMR_OFS_MODE 8'h00
`define DMR_OFS_AUX 8'h04
`define DMR_OFS_IPCHG 8'h08
`define DMR_OFS_ISTAT 8'h0C
`define DMR_OFS_IMASK 8'h10
`define DMR_OFS_CPHI 8'h14
`define DMR_OFS_CPLO 8'h18
`define DMR_OFS_OPR 8'h1C
`define DMR_OFS_CMD 8'h20
`define DMR_OFS_CSTAT 8'h24
`define DMR_OFS_OPCFG 8'h28

// mode one fields
`define DMR_M1_RTS_CTL 7
`define DMR_M1_RXINT_SEL 6
`define DMR_M1_ERR_MODE 5
`define DMR_M1_PAR_HI 4
`define DMR_M1_PAR_LO 3
`define DMR_M1_PAR_TYPE 2
`define DMR_M1_BITS_HI 1
`define DMR_M1_BITS_LO 0

// parity mode encodings
`define DMR_PAR_WITH 2'h0
`define DMR_PAR_FORCE 2'h1
`define DMR_PAR_NONE 2'h2
`define DMR_PAR_MDROP 2'h3

// aux control fields
`define DMR_AUX_BAUD_SET 7
`define DMR_AUX_CHG_HI 3
`define DMR_AUX_CHG_LO 0

// interrupt status / mask layout
`define DMR_IS_IN_CHANGE 7
`define DMR_IS_BRK_B 6
`define DMR_IS_RX_B 5
`define DMR_IS_TXRDY_B 4
`define DMR_IS_CTR 3
`define DMR_IS_BRK_A 2
`define DMR_IS_RX_A 1
`define DMR_IS_TXRDY_A 0

// output port bits
`define DMR_OP_RTS 0
`define DMR_OP_FOUR 4

// command register bits
`define DMR_CMD_SET_PTR 0
`define DMR_CMD_RST_ERR 1

// channel status bits
`define DMR_CS_BREAK 7
`define DMR_CS_FRAME 6
`define DMR_CS_PARITY 5
`define DMR_CS_RTS_HOLD 4
`define DMR_CS_PTR 3
`define DMR_CS_FIFO_FULL 1
`define DMR_CS_RECEIVER_READY 0

// reset values
`define DMR_RST_BYTE 8'h00
`define DMR_RST_OPR 8'h00

// axi responses
`define DMR_RESP_OKAY 2'h0
`define DMR_RESP_SLVERR 2'h2

`endif

/* File: hw/dmr_input_sync.v */
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser with agreement filter and change pulse
module dmr_input_sync #(
	parameter W = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire [W-1:0] pins,
	output reg [W-1:0] level,
	output reg [W-1:0] change
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;
	reg primed;

	// s1 only feeds s2; the filter looks at s2 and s3
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= {W{1'b0}};
			s2 <= {W{1'b0}};
			s3 <= {W{1'b0}};
			level <= {W{1'b0}};
			change <= {W{1'b0}};
			primed <= 1'b0;
		end else begin
			s1 <= pins;
			s2 <= s1;
			s3 <= s2;
			change <= {W{1'b0}};
			if (!primed) begin
				// first agreement after reset loads without a change event
				if (s2 == s3) begin
					level <= s3;
					primed <= 1'b1;
				end
			end else begin
				// follow s3 only where the last two stages agree, else hold
				level <= (s3 & ~(s2 ^ s3)) | (level & (s2 ^ s3));
				change <= (level ^ s3) & ~(s2 ^ s3);
			end
		end
	end
endmodule

`default_nettype wire

/* File: verification/dmr_mode_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmr_regs.vh"

module dmr_mode_regs_asserts #(
	parameter ADDR_W = 8,
	parameter NIN = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire rx_start_valid,
	input wire fifo_full,
	input wire chan_a_request_to_send_n,
	input wire parity_enable,
	input wire parity_forced,
	input wire multidrop,
	input wire [1:0] char_bits,
	input wire [15:0] counter_preset
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [2:0] bh = 3'h0;
	logic [2:0] sh = 3'h0;
	// causes land one or two cycles before the registered outputs move
	always @(posedge aclk) begin
		bh <= {bh[1:0], s_axi_bvalid};
		sh <= {sh[1:0], rx_start_valid && fifo_full};
	end
	wire wrote = s_axi_bvalid || bh != 3'h0;

	sequence write_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	rts_neg_cause_a: assert property (
		$rose(chan_a_request_to_send_n) |-> sh != 3'h0 || wrote) else $error("rts dropped");
	rts_back_cause_a: assert property (
		$fell(chan_a_request_to_send_n) |-> !fifo_full || !$past(fifo_full) || wrote)
		else $error("rts returned early");
	mdrop_excl_a: assert property (
		multidrop |-> !parity_enable && !parity_forced) else $error("multidrop with parity");
	forced_par_a: assert property (
		parity_forced |-> parity_enable) else $error("forced parity without bit");
	char_bits_a: assert property (
		$changed(char_bits) |-> wrote) else $error("char length moved alone");
	preset_cause_a: assert property (
		$changed(counter_preset) |-> wrote) else $error("preset moved alone");
	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	bad_read_a: assert property (
		read_taken ##0 (s_axi_araddr > 8'h28) |-> ##[1:3] (s_axi_rvalid &&
		s_axi_rresp == `DMR_RESP_SLVERR)) else $error("unmapped read accepted");
	wresp_bound_a: assert property (
		write_both |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
endmodule

bind dmr_mode_regs dmr_mode_regs_asserts #(.ADDR_W(ADDR_W), .NIN(NIN)) i_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_start_valid, .fifo_full,
	.chan_a_request_to_send_n, .parity_enable, .parity_forced, .multidrop, .char_bits,
	.counter_preset
);
`default_nettype wire

/* File: verification/dmr_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

// receive fifo and remote sender; ignores request-to-send to stress flow control
module dmr_far_end (
	input wire logic aclk,
	output var logic rx_start_valid,
	output var logic fifo_full,
	output var logic receiver_ready,
	output var logic rx_top_load,
	output var logic [2:0] top_err
);
	initial begin
		rx_start_valid = 1'b0;
		fifo_full = 1'b0;
		receiver_ready = 1'b0;
		rx_top_load = 1'b0;
		top_err = 3'h0;
	end
	// fifo fill levels
	task automatic levels(input logic full, input logic ready);
		@(posedge aclk);
		fifo_full <= full;
		receiver_ready <= ready;
	endtask
	// one valid start bit
	task automatic start_bit();
		@(posedge aclk);
		rx_start_valid <= 1'b1;
		@(posedge aclk);
		rx_start_valid <= 1'b0;
	endtask
	// new top character; flags {break, framing, parity} stay with it
	task automatic push(input logic [2:0] e);
		@(posedge aclk);
		top_err <= e;
		rx_top_load <= 1'b1;
		@(posedge aclk);
		rx_top_load <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmr_regs.vh"

module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [6:0] src = 7'h00;
	logic [3:0] in_pins = 4'h0;
	logic [31:0] rd_d;
	logic [1:0] rd_r;
	logic [1:0] wr_b;
	int error_cnt = 0;
	int cmp_count = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, char_bits;
	wire [31:0] s_axi_rdata;
	wire chan_a_request_to_send_n, output_bit_four, intr_request, parity_enable;
	wire parity_forced, parity_odd, multidrop, addr_data_polarity, baud_set_two;
	wire [15:0] counter_preset;
	wire [7:0] chan_a_mode_two_out;
	wire rx_start_valid, fifo_full, receiver_ready, rx_top_load;
	wire [2:0] top_err;

	always #5 aclk = ~aclk;

	dmr_mode_regs i_dmr_mode_regs (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_start_valid, .fifo_full,
		.receiver_ready, .rx_top_load, .top_framing_error(top_err[1]),
		.top_parity_error(top_err[0]), .top_break(top_err[2]),
		.transmitter_ready_a(src[0]), .break_change_a(src[2]), .counter_ready(src[3]),
		.transmitter_ready_b(src[4]), .rx_int_b(src[5]), .break_change_b(src[6]), .in_pins,
		.chan_a_request_to_send_n, .output_bit_four, .intr_request, .parity_enable,
		.parity_forced, .parity_odd, .multidrop, .addr_data_polarity, .char_bits,
		.baud_set_two, .counter_preset, .chan_a_mode_two_out
	);
	dmr_far_end i_dmr_far_end (
		.aclk, .rx_start_valid, .fifo_full, .receiver_ready, .rx_top_load, .top_err
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		wr_b = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50) error_cnt++;
		repeat (3) @(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50) error_cnt++;
		@(posedge aclk);
	endtask
	// pointer back to mode one, then write it
	task automatic wmode(input logic [7:0] d);
		wr(`DMR_OFS_CMD, 8'h01);
		wr(`DMR_OFS_MODE, d);
	endtask
	// every parity code and type; pointer walk
	task automatic t_mode();
		logic [1:0] c;
		logic t;
		for (int i = 0; i < 8; i++) begin
			c = i[2:1];
			t = i[0];
			wmode({3'b000, c, t, c});
			chk({25'h0, parity_enable, parity_forced, multidrop, char_bits, parity_odd,
				addr_data_polarity}, {25'h0, c < 2'h2, c == 2'h1, c == 2'h3, c,
				t && c < 2'h2, t && c == 2'h3});
		end
		wr(`DMR_OFS_CMD, 8'h01);
		rd(`DMR_OFS_MODE);
		chk(rd_d, 32'h1F);
		rd(`DMR_OFS_MODE);
		chk(rd_d, 32'h00);
		wr(`DMR_OFS_MODE, 8'hA5);
		chk({24'h0, chan_a_mode_two_out}, 32'hA5);
		rd(`DMR_OFS_MODE);
		chk(rd_d, 32'hA5);
	endtask
	// flow control on a full fifo
	task automatic t_rts();
		wmode(8'h80);
		wr(`DMR_OFS_OPR, 8'h01);
		chk({31'h0, chan_a_request_to_send_n}, 32'h0);
		i_dmr_far_end.levels(1'b0, 1'b1);
		i_dmr_far_end.start_bit();
		repeat (3) @(posedge aclk);
		chk({31'h0, chan_a_request_to_send_n}, 32'h0);
		i_dmr_far_end.levels(1'b1, 1'b1);
		i_dmr_far_end.start_bit();
		repeat (3) @(posedge aclk);
		chk({31'h0, chan_a_request_to_send_n}, 32'h1);
		rd(`DMR_OFS_OPR);
		chk(rd_d, 32'h01);
		i_dmr_far_end.levels(1'b0, 1'b0);
		repeat (3) @(posedge aclk);
		chk({31'h0, chan_a_request_to_send_n}, 32'h0);
		wr(`DMR_OFS_OPR, 8'h00);
		chk({31'h0, chan_a_request_to_send_n}, 32'h1);
	endtask
	// receiver source select, pin four, mask per source
	task automatic t_intr();
		wr(`DMR_OFS_IMASK, 8'h02);
		wmode(8'h00);
		wr(`DMR_OFS_OPCFG, 8'h10);
		i_dmr_far_end.levels(1'b0, 1'b1);
		repeat (3) @(posedge aclk);
		chk({30'h0, intr_request, output_bit_four}, 32'h2);
		wmode(8'h40);
		chk({30'h0, intr_request, output_bit_four}, 32'h1);
		i_dmr_far_end.levels(1'b1, 1'b0);
		repeat (3) @(posedge aclk);
		chk({30'h0, intr_request, output_bit_four}, 32'h2);
		i_dmr_far_end.levels(1'b0, 1'b0);
		for (int i = 0; i < 7; i++) if (i != 1) begin
			src <= 7'(1 << i);
			wr(`DMR_OFS_IMASK, 8'(1 << i));
			rd(`DMR_OFS_ISTAT);
			chk(rd_d, 32'h1 << i);
			chk({31'h0, intr_request}, 32'h1);
			wr(`DMR_OFS_IMASK, ~8'(1 << i));
			chk({31'h0, intr_request}, 32'h0);
		end
		src <= 7'h00;
	endtask
	// character against block error reporting
	task automatic t_err();
		wmode(8'h00);
		i_dmr_far_end.push(3'b111);
		rd(`DMR_OFS_CSTAT);
		chk({29'h0, rd_d[7:5]}, 32'h7);
		i_dmr_far_end.push(3'b000);
		rd(`DMR_OFS_CSTAT);
		chk({29'h0, rd_d[7:5]}, 32'h0);
		wmode(8'h20);
		wr(`DMR_OFS_CMD, 8'h02);
		i_dmr_far_end.push(3'b010);
		i_dmr_far_end.push(3'b000);
		rd(`DMR_OFS_CSTAT);
		chk({29'h0, rd_d[7:5]}, 32'h2);
		wr(`DMR_OFS_CMD, 8'h02);
		rd(`DMR_OFS_CSTAT);
		chk({29'h0, rd_d[7:5]}, 32'h0);
	endtask
	// rate set, preset, input change with enable on and off, bad address
	task automatic t_misc();
		wr(`DMR_OFS_AUX, 8'h84);
		wr(`DMR_OFS_CPHI, 8'h12);
		wr(`DMR_OFS_CPLO, 8'h34);
		chk({30'h0, wr_b}, {30'h0, `DMR_RESP_OKAY});
		chk({15'h0, baud_set_two, counter_preset}, 32'h11234);
		wr(`DMR_OFS_IMASK, 8'h80);
		in_pins <= 4'h4;
		repeat (8) @(posedge aclk);
		chk({31'h0, intr_request}, 32'h1);
		rd(`DMR_OFS_ISTAT);
		chk(rd_d, 32'h80);
		rd(`DMR_OFS_IPCHG);
		chk(rd_d, 32'h44);
		rd(`DMR_OFS_IPCHG);
		chk(rd_d, 32'h04);
		in_pins <= 4'h6;
		repeat (8) @(posedge aclk);
		rd(`DMR_OFS_ISTAT);
		chk(rd_d, 32'h00);
		rd(`DMR_OFS_IPCHG);
		chk(rd_d, 32'h26);
		// a falling pin must flag and drop its level
		in_pins <= 4'h2;
		repeat (8) @(posedge aclk);
		rd(`DMR_OFS_IPCHG);
		chk(rd_d, 32'h42);
		rd(8'h2C);
		chk({30'h0, rd_r}, {30'h0, `DMR_RESP_SLVERR});
		wr(8'h2C, 8'h55);
		chk({30'h0, wr_b}, {30'h0, `DMR_RESP_SLVERR});
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_mode();
		t_rts();
		t_intr();
		t_err();
		t_misc();
		summarize();
	end
	// hang guard, well above the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		summarize();
	end
endmodule
`default_nettype wire
